// file: common/ocr_regs.vh
`ifndef OCR_REGS_VH
`define OCR_REGS_VH

// Register byte offsets on the APB bus.
`define OCR_CTRL        8'h00
`define OCR_CLIP        8'h04
`define OCR_TRIM        8'h08
`define OCR_DIAG        8'h0c
`define OCR_CUST        8'h10
`define OCR_STAT        8'h14
`define OCR_HICNT       8'h18
`define OCR_LOCNT       8'h1c

// Field positions.
`define OCR_CTRL_MODE   1:0
`define OCR_CTRL_SETPT  2
`define OCR_CLIP_LO     6:0
`define OCR_CLIP_HI     14:8
`define OCR_TRIM_CODE   3:0
`define OCR_DIAG_CFG    2:0
`define OCR_CUST_BYTE   7:0

// Reset values.
`define OCR_MODE_RST    2'h0
`define OCR_SETPT_RST   1'h0
`define OCR_LO_RST      7'h00
`define OCR_HI_RST      7'h7f
`define OCR_TRIM_RST    4'h0
`define OCR_DIAG_RST    3'h0
`define OCR_CUST_RST    8'h00

// Output modes.
`define OCR_MODE_RATIO  2'h0
`define OCR_MODE_ABS    2'h1
`define OCR_MODE_1V     2'h2
`define OCR_MODE_DIG    2'h3

// High reference choices for the output converter.
`define OCR_REF_VDD     2'h0
`define OCR_REF_REG     2'h1
`define OCR_REF_1V      2'h2

// Timing: system clock and internal oscillator rates in Hz.
`define OCR_CLK_HZ      40000000
`define OCR_OSC_HZ      570000

`endif

// file: design/ocr_clip_cmp.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Clipping comparator
// ----------------------------------------------------------------
module ocr_clip_cmp #(
    parameter DW = 14
) (
    input  wire [DW-1:0] sample,
    input  wire [6:0]    upField,
    input  wire [6:0]    loField,
    output reg  [DW-1:0] limited,
    output reg           hitHigh,
    output reg           hitLow
);

    wire [DW-1:0] upThr;
    wire [DW-1:0] loThr;

    // Upper threshold padded with ones and lower threshold with zeros, above and below the field.
    assign upThr = {2'b11, upField, 5'b11111}; // [RULE_03]
    assign loThr = {2'b00, loField, 5'b00000}; // [RULE_04]

    // Unsigned compare on every sample; high side checked first.
    always @* begin
        hitHigh = (sample > upThr); // [RULE_12]
        hitLow  = (sample < loThr); // [RULE_12]
        if (hitHigh) begin
            limited = upThr; // [RULE_05]
        end else if (hitLow) begin
            limited = loThr; // [RULE_05]
        end else begin
            limited = sample; // [RULE_05]
        end
    end

endmodule // ocr_clip_cmp

`default_nettype wire

// file: design/ocr_ref_decode.v
`include "ocr_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Reference trim and converter reference decode
// ----------------------------------------------------------------
module ocr_ref_decode (
    input  wire [3:0] trimCode,
    input  wire [7:0] backupByte,
    input  wire [1:0] outMode,
    output reg  [3:0] trimRank,
    output reg        trimMismatch,
    output reg  [1:0] dacRef
);

    // Rank 0 is the highest reference; flipping the top bit of the
    // code gives 1000 rank 0 up to 0111 rank 15.
    always @* begin
        trimRank     = {~trimCode[3], trimCode[2:0]}; // [RULE_06]
        trimMismatch = (backupByte[3:0] != trimCode); // [RULE_11]
        case (outMode)
            `OCR_MODE_1V:  dacRef = `OCR_REF_1V; // [RULE_09]
            `OCR_MODE_ABS: dacRef = `OCR_REF_REG;
            default:       dacRef = `OCR_REF_VDD;
        endcase
    end

endmodule // ocr_ref_decode

`default_nettype wire

// file: design/ocr_top.v
// How it works
// [RULE_01] A 12-bit converter drives ratiometric and absolute analog modes, mode is configurable.
// [RULE_02] Both clipping limits apply in analog and in digital output modes.
// [RULE_03] Upper threshold is two ones, upper field, then five ones.
// [RULE_04] Lower threshold is two zeros, lower field, then five zeros.
// [RULE_05] Above upper gives upper, below lower gives lower, else value passes.
// [RULE_06] Trim code 1000 is highest reference, ascending codes wrap to 0111 lowest.
// [RULE_07] Diagnostic config field enables output short-circuit current limiting.
// [RULE_08] Set-point select picks about 5.0 or 5.5 volts; trim fine-adjusts it.
// [RULE_09] In 0 to 1 volt mode the trimmed 1 volt reference is converter top.
// [RULE_10] After reset release the oscillator starts at about 570 kHz.
// [RULE_11] Host checks trim code against its backup byte and restores it if different.
// [RULE_12] Bridge value is compared unsigned against both thresholds on every sample.
//
// Register access over APB and the address map were decided locally.
`include "ocr_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module ocr_top #(
    parameter DW = 14,
    parameter CW = 16
) (
    input  wire          clk,
    input  wire          nrst,
    input  wire [7:0]    paddr,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire [DW-1:0] sampleIn,
    input  wire          sampleValid,
    output reg           oscClk,
    output reg           oscRunning,
    output reg  [11:0]   dacCode,
    output reg           dacLoad,
    output reg           dacEnable,
    output reg  [1:0]    dacHighRef,
    output reg  [DW-1:0] digOut,
    output reg           digValid,
    output reg           shortProtEn,
    output reg           regSetpoint,
    output reg  [3:0]    refTrimCode,
    output reg  [3:0]    refTrimRank
);

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------

    // Half period of the oscillator in system cycles, rounded down.
    localparam [31:0]  OSC_HALF = `OCR_CLK_HZ / (2 * `OCR_OSC_HZ);
    localparam [7:0]   OSC_LAST = OSC_HALF[7:0] - 8'h01;

    localparam [1:0] ST_BOOT  = 2'h0;
    localparam [1:0] ST_START = 2'h1;
    localparam [1:0] ST_RUN   = 2'h2;

    // ------------------------------------------------------------
    // Configuration and status storage
    // ------------------------------------------------------------

    reg  [1:0]    outMode;
    reg  [6:0]    upperClipField;
    reg  [6:0]    lowerClipField;
    reg  [3:0]    trimCode;
    reg  [2:0]    diagnosticCfg;
    reg  [7:0]    customerTraceByte0;
    reg  [DW-1:0] lastOut;
    reg           lastHigh;
    reg           lastLow;
    reg  [CW-1:0] highCount;
    reg  [CW-1:0] lowCount;
    reg  [1:0]    state;
    reg  [1:0]    next_state;
    reg  [7:0]    oscCnt;
    reg           oscToggle;

    wire [DW-1:0] limited;
    wire          hitHigh;
    wire          hitLow;
    wire [3:0]    trimRank;
    wire          trimMismatch;
    wire [1:0]    dacRef;

    wire          access;
    wire          wrEn;
    wire          take;
    reg  [31:0]   next_prdata;
    reg           next_pslverr;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------

    ocr_clip_cmp #(
        .DW      (DW)
    ) uClip (
        .sample  (sampleIn),
        .upField (upperClipField),
        .loField (lowerClipField),
        .limited (limited),
        .hitHigh (hitHigh),
        .hitLow  (hitLow)
    );

    ocr_ref_decode uRef (
        .trimCode     (trimCode),
        .backupByte   (customerTraceByte0),
        .outMode      (outMode),
        .trimRank     (trimRank),
        .trimMismatch (trimMismatch),
        .dacRef       (dacRef)
    );

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------

    // Registered ready costs one wait state but keeps every output
    // on a flop; the access completes on the edge that sees it high.
    assign access = psel & penable;
    assign wrEn   = access & pready & pwrite;
    assign take   = (state == ST_RUN) & sampleValid;

    // Read mux; unmapped offsets read zero with an error answer.
    always @* begin
        next_prdata  = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            `OCR_CTRL: begin
                next_prdata[`OCR_CTRL_MODE] = outMode;
                next_prdata[`OCR_CTRL_SETPT] = regSetpoint;
            end
            `OCR_CLIP: begin
                next_prdata[`OCR_CLIP_LO] = lowerClipField;
                next_prdata[`OCR_CLIP_HI] = upperClipField;
            end
            `OCR_TRIM: begin
                next_prdata[`OCR_TRIM_CODE] = trimCode;
            end
            `OCR_DIAG: begin
                next_prdata[`OCR_DIAG_CFG] = diagnosticCfg;
            end
            `OCR_CUST: begin
                next_prdata[`OCR_CUST_BYTE] = customerTraceByte0;
            end
            `OCR_STAT: begin
                next_prdata[13:0]  = lastOut;
                next_prdata[16]    = lastHigh;
                next_prdata[17]    = lastLow;
                next_prdata[20]    = trimMismatch; // [RULE_11]
                next_prdata[24]    = oscRunning;
                next_prdata[31:28] = trimRank;
            end
            `OCR_HICNT: begin
                next_prdata[CW-1:0] = highCount;
            end
            `OCR_LOCNT: begin
                next_prdata[CW-1:0] = lowCount;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    // Handshake: ready rises one cycle into the access phase.
    always @(posedge clk) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            if (access & ~pready) begin
                prdata  <= pwrite ? 32'h00000000 : next_prdata;
                pslverr <= next_pslverr;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Writable configuration; stands in for the nonvolatile bits.
    always @(posedge clk) begin
        if (!nrst) begin
            outMode            <= `OCR_MODE_RST;
            regSetpoint        <= `OCR_SETPT_RST;
            upperClipField     <= `OCR_HI_RST;
            lowerClipField     <= `OCR_LO_RST;
            trimCode           <= `OCR_TRIM_RST;
            diagnosticCfg      <= `OCR_DIAG_RST;
            customerTraceByte0 <= `OCR_CUST_RST;
        end else if (wrEn) begin
            case (paddr)
                `OCR_CTRL: begin
                    outMode     <= pwdata[`OCR_CTRL_MODE]; // [RULE_01]
                    regSetpoint <= pwdata[`OCR_CTRL_SETPT]; // [RULE_08]
                end
                `OCR_CLIP: begin
                    lowerClipField <= pwdata[`OCR_CLIP_LO];
                    upperClipField <= pwdata[`OCR_CLIP_HI];
                end
                `OCR_TRIM: begin
                    trimCode <= pwdata[`OCR_TRIM_CODE];
                end
                `OCR_DIAG: begin
                    diagnosticCfg <= pwdata[`OCR_DIAG_CFG];
                end
                `OCR_CUST: begin
                    customerTraceByte0 <= pwdata[`OCR_CUST_BYTE];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Start-up sequence and oscillator
    // ------------------------------------------------------------

    // Boot waits one cycle after reset, then for the first
    // oscillator edge, before samples are accepted.
    always @* begin
        case (state)
            ST_BOOT:  next_state = ST_START;
            ST_START: next_state = oscToggle ? ST_RUN : ST_START;
            ST_RUN:   next_state = ST_RUN;
            default:  next_state = ST_BOOT;
        endcase
    end

    // The divider runs from reset release, giving about 570 kHz.
    always @(posedge clk) begin
        if (!nrst) begin
            state      <= ST_BOOT;
            oscCnt     <= 8'h00;
            oscClk     <= 1'b0;
            oscToggle  <= 1'b0;
            oscRunning <= 1'b0;
        end else begin
            state      <= next_state;
            oscRunning <= (next_state == ST_RUN); // [RULE_10]
            oscToggle  <= (oscCnt == OSC_LAST);
            if (oscCnt == OSC_LAST) begin
                oscCnt <= 8'h00;
                oscClk <= ~oscClk; // [RULE_10]
            end else begin
                oscCnt <= oscCnt + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------

    // The clipped value goes to the converter or to the digital
    // path; the same limits apply either way.
    always @(posedge clk) begin
        if (!nrst) begin
            dacCode  <= 12'h000;
            dacLoad  <= 1'b0;
            digOut   <= {DW{1'b0}};
            digValid <= 1'b0;
            lastOut  <= {DW{1'b0}};
            lastHigh <= 1'b0;
            lastLow  <= 1'b0;
        end else begin
            dacLoad  <= take & (outMode != `OCR_MODE_DIG);
            digValid <= take & (outMode == `OCR_MODE_DIG);
            if (take) begin
                lastOut  <= limited; // [RULE_02]
                lastHigh <= hitHigh;
                lastLow  <= hitLow;
                if (outMode == `OCR_MODE_DIG) begin
                    digOut <= limited; // [RULE_02]
                end else begin
                    dacCode <= limited[DW-1:DW-12]; // [RULE_01]
                end
            end
        end
    end

    // Saturating clip counters; a write clears, but a clip in the
    // same cycle still counts so no event is lost.
    always @(posedge clk) begin
        if (!nrst) begin
            highCount <= {CW{1'b0}};
            lowCount  <= {CW{1'b0}};
        end else begin
            if (wrEn && paddr == `OCR_HICNT) begin
                highCount <= {{(CW-1){1'b0}}, take & hitHigh};
            end else if (take & hitHigh & ~&highCount) begin
                highCount <= highCount + {{(CW-1){1'b0}}, 1'b1};
            end
            if (wrEn && paddr == `OCR_LOCNT) begin
                lowCount <= {{(CW-1){1'b0}}, take & hitLow};
            end else if (take & hitLow & ~&lowCount) begin
                lowCount <= lowCount + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // Analog control outputs
    // ------------------------------------------------------------

    // Protection is on for any nonzero diagnostic setting; the
    // converter is idle in digital mode to save power.
    always @(posedge clk) begin
        if (!nrst) begin
            dacEnable   <= 1'b0;
            dacHighRef  <= `OCR_REF_VDD;
            shortProtEn <= 1'b0;
            refTrimCode <= `OCR_TRIM_RST;
            refTrimRank <= 4'h0;
        end else begin
            dacEnable   <= (outMode != `OCR_MODE_DIG); // [RULE_01]
            dacHighRef  <= dacRef; // [RULE_09]
            shortProtEn <= (diagnosticCfg != 3'h0); // [RULE_07]
            refTrimCode <= trimCode; // [RULE_08]
            refTrimRank <= trimRank; // [RULE_06]
        end
    end

endmodule // ocr_top

`default_nettype wire

// file: bench/ocr_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Output stage checker
// ----------------------------------------------------------------
module ocr_top_properties #(
    parameter DW = 14
) (
    input wire logic          clk,
    input wire logic          nrst,
    input wire logic [DW-1:0] sampleIn,
    input wire logic          sampleValid,
    input wire logic          oscClk,
    input wire logic          oscRunning,
    input wire logic [11:0]   dacCode,
    input wire logic          dacLoad,
    input wire logic          dacEnable,
    input wire logic [DW-1:0] digOut,
    input wire logic          digValid,
    input wire logic [3:0]    refTrimCode,
    input wire logic [3:0]    refTrimRank
);
    logic [7:0] stay;
    logic       lastOsc;
    wire        take = sampleValid && oscRunning;

    // Cycles since the oscillator output last moved; cleared while stopped so start-up is not flagged.
    always @(posedge clk) begin
        lastOsc <= oscClk;
        stay    <= (!nrst || !oscRunning || oscClk != lastOsc) ? 8'h00 : stay + 8'h01;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_anaLoad; take && dacEnable |=> dacLoad && !digValid; endproperty
    a_anaLoad: assert property (p_anaLoad) else $error("analog sample not loaded");
    property p_digOut; take && !dacEnable |=> digValid && !dacLoad; endproperty
    a_digOut: assert property (p_digOut) else $error("digital sample not sent");
    property p_pass; take && !dacEnable && sampleIn[13:12] == 2'b01 |=> digOut == $past(sampleIn); endproperty
    a_pass: assert property (p_pass) else $error("in-range value altered");
    property p_upper;
        take && !dacEnable && sampleIn == 14'h3fff |=> digOut[13:12] == 2'b11 && digOut[4:0] == 5'h1f;
    endproperty
    a_upper: assert property (p_upper) else $error("upper clip shape wrong");
    property p_lower; take && !dacEnable && sampleIn == 14'h0000 |=> digOut[13:12] == 2'b00 && digOut[4:0] == 5'h00;
    endproperty
    a_lower: assert property (p_lower) else $error("lower clip shape wrong");
    property p_dacTop; take && dacEnable && sampleIn[13:12] == 2'b10 |=> dacCode == $past(sampleIn[13:2]); endproperty
    a_dacTop: assert property (p_dacTop) else $error("converter code wrong");
    property p_rank;
        $past(nrst, 3) && $stable(refTrimCode) && $past(refTrimCode, 2) == refTrimCode
            |-> refTrimRank == (refTrimCode ^ 4'h8);
    endproperty
    a_rank: assert property (p_rank) else $error("trim rank wrong");
    property p_oscUp; $rose(nrst) |-> ##[1:60] oscRunning; endproperty
    a_oscUp: assert property (p_oscUp) else $error("oscillator did not start");
    property p_oscRate; oscRunning |-> stay < 8'd40; endproperty
    a_oscRate: assert property (p_oscRate) else $error("oscillator stalled");

    c_clipHigh: cover property (take && !dacEnable && sampleIn == 14'h3fff);
    c_analog: cover property (take && dacEnable);
    c_start: cover property ($rose(oscRunning));
endmodule // ocr_top_properties

`default_nettype wire

// file: bench/ocr_load_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Output load model
// ----------------------------------------------------------------
module ocr_load_model (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [11:0] dacCode,
    input wire logic        dacLoad,
    input wire logic [13:0] digOut,
    input wire logic        digValid,
    output var logic [13:0] seen,
    output var int          count
);
    // The load keeps the last value presented; the converter resolves only 12 bits, so its low bits read 0.
    always @(posedge clk) begin
        if (!nrst) begin
            count <= 0;
        end else if (dacLoad) begin
            seen  <= {dacCode, 2'b00};
            count <= count + 1;
        end else if (digValid) begin
            seen  <= digOut;
            count <= count + 1;
        end
    end
endmodule // ocr_load_model

`default_nettype wire

// file: bench/ocr_top_tb.sv
`include "ocr_regs.vh"
`timescale 1ns/1ps
`default_nettype none

bind ocr_top ocr_top_properties #(.DW(DW)) i_ocr_top_properties (
    .clk(clk), .nrst(nrst), .sampleIn(sampleIn), .sampleValid(sampleValid), .oscClk(oscClk),
    .oscRunning(oscRunning), .dacCode(dacCode), .dacLoad(dacLoad), .dacEnable(dacEnable),
    .digOut(digOut), .digValid(digValid), .refTrimCode(refTrimCode), .refTrimRank(refTrimRank));

module ocr_top_tb;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sampleValid = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [13:0] sampleIn = 14'h0, digOut, seen;
    logic [11:0] dacCode;
    logic [1:0]  dacHighRef;
    logic [3:0]  refTrimCode, refTrimRank;
    logic [6:0]  upF, loF;
    logic [15:0] rnd = 16'd52995;
    logic        pready, pslverr, oscClk, oscRunning, dacLoad, dacEnable, digValid, shortProtEn, regSetpoint, er;
    int          fails = 0, checks = 0, count, n, nHi = 0, nLo = 0;

    always #12.5 clk = ~clk;

    ocr_top i_ocr_top (
        .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleIn(sampleIn),
        .sampleValid(sampleValid), .oscClk(oscClk), .oscRunning(oscRunning), .dacCode(dacCode),
        .dacLoad(dacLoad), .dacEnable(dacEnable), .dacHighRef(dacHighRef), .digOut(digOut),
        .digValid(digValid), .shortProtEn(shortProtEn), .regSetpoint(regSetpoint),
        .refTrimCode(refTrimCode), .refTrimRank(refTrimRank));

    ocr_load_model i_ocr_load_model (
        .clk(clk), .nrst(nrst), .dacCode(dacCode), .dacLoad(dacLoad), .digOut(digOut),
        .digValid(digValid), .seen(seen), .count(count));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Reference clip worked out in plain integers from the threshold shapes.
    function int clip(input int v, input int u, input int l);
        int hi, lw;
        hi = 'h3000 + u * 32 + 31;
        lw = l * 32;
        return v > hi ? hi : (v < lw ? lw : v);
    endfunction

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (e !== s) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; two idle edges after it let registered outputs settle before they are read.
    // The wait for ready has no limit of its own: a hung slave is caught by the watchdog.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // A single sample; the load model has latched the answer two edges after it is taken.
    task samp(input logic [13:0] v, input logic [13:0] mask);
        sampleIn <= v;
        sampleValid <= 1'b1;
        @(posedge clk) sampleValid <= 1'b0;
        repeat (2) @(posedge clk);
        chk("output", clip(v, upF, loF) & mask, seen);
        if (clip(v, upF, loF) < v) nHi++;
        if (clip(v, upF, loF) > v) nLo++;
    endtask

    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        // A sample offered while the oscillator is still starting must be dropped; the load count shows it.
        sampleIn <= 14'h1234;
        sampleValid <= 1'b1;
        @(posedge clk) sampleValid <= 1'b0;
        chk("shortProtReset", 0, shortProtEn);
        apb(1'b0, `OCR_CLIP, 32'h0);
        chk("clipReset", 32'h7f00, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 1, er);
        apb(1'b1, `OCR_DIAG, 32'h5);
        chk("shortProt", 1, shortProtEn);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `OCR_CTRL, m + 4 * (m % 2));
            chk("dacEnable", m != 3, dacEnable);
            chk("setpoint", m % 2, regSetpoint);
            chk("highRef", m < 3 ? m : 0, dacHighRef);
        end
        for (int t = 0; t < 16; t++) begin
            apb(1'b1, `OCR_TRIM, t);
            chk("rank", t ^ 8, refTrimRank);
        end
        // The host compares the trim against its backup byte and restores it when they differ.
        apb(1'b1, `OCR_CUST, 32'ha5);
        apb(1'b0, `OCR_STAT, 32'h0);
        chk("trimDiffers", 1, rd[20]);
        apb(1'b0, `OCR_TRIM, 32'h0);
        if (rd[3:0] !== 4'h5) apb(1'b1, `OCR_TRIM, 32'h5);
        chk("trimRestore", 5, refTrimCode);
        apb(1'b0, `OCR_STAT, 32'h0);
        chk("trimMatches", 0, rd[20]);
        n = 0;
        while (oscRunning !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("oscRunning", 1, oscRunning);
        // Digital then analog output, each with fresh random limits and both extremes.
        for (int p = 0; p < 2; p++) begin
            rnd = lfsr(rnd);
            upF = rnd[6:0];
            loF = rnd[14:8];
            apb(1'b1, `OCR_CTRL, p ? 32'h0 : 32'h3);
            apb(1'b1, `OCR_CLIP, {17'h0, upF, 1'b0, loF});
            samp(14'h0000, p ? 14'h3ffc : 14'h3fff);
            samp(14'h3fff, p ? 14'h3ffc : 14'h3fff);
            for (int i = 0; i < 30; i++) begin
                rnd = lfsr(rnd);
                samp(rnd[13:0], p ? 14'h3ffc : 14'h3fff);
            end
        end
        chk("loads", 64, count);
        apb(1'b0, `OCR_HICNT, 32'h0);
        chk("highCount", nHi, rd);
        apb(1'b0, `OCR_LOCNT, 32'h0);
        chk("lowCount", nLo, rd);
        give_verdict;
    end

    // Watchdog at 20000 cycles, far beyond the few hundred cycles the scenarios need.
    initial begin
        #(25 * 20000);
        fails++;
        give_verdict;
    end
endmodule // ocr_top_tb

`default_nettype wire
